// [hw/platform_csr_bank.sv]
// Platform control/status register bank: region attributes, error capture.
module platform_csr_bank
  import platform_csr_pkg::*;
(
  input  wire logic         I_CLOCK,
  input  wire logic         I_RST_N,
  input  wire csr_req_t     I_CSR_REQ,
  output csr_rsp_t          O_CSR_RSP,
  input  wire logic [31:0]  I_FETCH_ADDR,
  input  wire logic         I_FETCH_LOCAL,
  output mem_attr_t         O_FETCH_ATTR,
  input  wire logic [31:0]  I_DATA_ADDR,
  input  wire logic         I_DATA_LOCAL,
  output mem_attr_t         O_DATA_ATTR,
  output logic              O_DATA_FENCE_REQ,
  output logic              O_INSTR_FENCE_REQ,
  input  wire logic         I_BUS_ERR,
  input  wire logic         I_BUS_ERR_LOAD,
  input  wire logic [31:0]  I_BUS_ERR_ADDR,
  input  wire logic         I_NMI_PIN,
  output logic              O_NMI_REQ,
  output logic [31:0]       O_NMI_CAUSE,
  output logic [31:0]       O_ERR_CAPTURE,
  output logic              O_ERR_LOCKED,
  input  wire store_t       I_STORE,
  output logic              O_LOCAL_RMW_REQ,
  output logic [31:0]       O_LOCAL_RMW_ADDR,
  output logic              O_SYS_WR_VALID,
  output logic [31:0]       O_SYS_WR_ADDR,
  output logic [3:0]        O_SYS_WR_STRB
);

  // Every piece of state in the bank, registered as one word.
  typedef struct packed
  {
    logic [31:0] region_attr;
    logic [31:0] err_addr;
    logic        locked;
    csr_rsp_t    rsp;
    mem_attr_t   fetch_attr;
    mem_attr_t   data_attr;
    logic        data_fence;
    logic        instr_fence;
    logic        nmi_req;
    logic [31:0] nmi_cause;
    logic        nmi_pin_prev;
    logic        pin_pending;
    logic        local_rmw;
    logic [31:0] local_rmw_addr;
    logic        sys_wr_valid;
    logic [31:0] sys_wr_addr;
    logic [3:0]  sys_wr_strb;
  } bank_state_t;

  bank_state_t state;
  bank_state_t next_state;

  mem_attr_t   fetch_attr_comb;
  mem_attr_t   data_attr_comb;

  logic        sel_region;
  logic        sel_sync;
  logic        sel_unlock;
  logic        sel_capture;
  logic        csr_write;
  logic        sync_allowed;
  logic        pin_edge;
  logic        err_take;
  logic        partial;

  // Fetch attributes, looked up from the live attribute word.
  region_attr_resolve fetch_resolve
  (
    .i_attr_word    (state.region_attr),
    .i_addr         (I_FETCH_ADDR),
    .i_kind         (ACCESS_FETCH),
    .i_local_target (I_FETCH_LOCAL),
    .o_attr         (fetch_attr_comb)
  );

  // Load/store attributes, looked up from the same word.
  region_attr_resolve data_resolve
  (
    .i_attr_word    (state.region_attr),
    .i_addr         (I_DATA_ADDR),
    .i_kind         (ACCESS_DATA),
    .i_local_target (I_DATA_LOCAL),
    .o_attr         (data_attr_comb)
  );

  // Address decode of the four registers of the bank.
  assign sel_region   = I_CSR_REQ.valid
                        && (I_CSR_REQ.addr == REGION_ATTR_ADDR);
  assign sel_sync     = I_CSR_REQ.valid
                        && (I_CSR_REQ.addr == SYNC_TRIGGER_ADDR);
  assign sel_unlock   = I_CSR_REQ.valid
                        && (I_CSR_REQ.addr == ERR_UNLOCK_ADDR);
  assign sel_capture  = I_CSR_REQ.valid
                        && (I_CSR_REQ.addr == ERR_CAPTURE_ADDR);
  assign csr_write    = I_CSR_REQ.valid && I_CSR_REQ.we;

  // The trigger register exists only for a debugger halted in debug mode.
  assign sync_allowed = sel_sync && I_CSR_REQ.debug_mode;

  // The pin is taken as synchronous; a rising edge is one request.
  assign pin_edge     = I_NMI_PIN && !state.nmi_pin_prev;

  // A bus error is only taken while the capture is open.
  assign err_take     = I_BUS_ERR && !state.locked;

  // A store that leaves any byte lane unwritten is partial.
  assign partial      = I_STORE.strb != FULL_STRB;

  // Next-state logic of the whole bank.
  always_comb
  begin
    next_state = state;

    // Answer every access one cycle later; unmapped numbers are not ours.
    next_state.rsp.ack     = I_CSR_REQ.valid;
    next_state.rsp.hit     = sel_region || sel_sync || sel_unlock
                             || sel_capture;
    next_state.rsp.illegal = 1'b0;
    next_state.rsp.rdata   = READ_ZERO;

    // Attribute word: every value is legal, so it is stored as written.
    if (sel_region)
    begin
      next_state.rsp.rdata = state.region_attr;
      if (csr_write)
      begin
        next_state.region_attr = I_CSR_REQ.wdata;
      end
    end

    // Trigger bits are pulses; they never hold a value to read back.
    next_state.data_fence  = 1'b0;
    next_state.instr_fence = 1'b0;
    if (sel_sync && !I_CSR_REQ.debug_mode)
    begin
      next_state.rsp.illegal = 1'b1;
    end
    else if (sync_allowed)
    begin
      next_state.rsp.rdata = READ_ZERO;
      if (csr_write)
      begin
        next_state.data_fence  = I_CSR_REQ.wdata[DATA_FENCE_BIT];
        next_state.instr_fence = I_CSR_REQ.wdata[INSTR_FENCE_BIT];
      end
    end

    // Capture register lives in read-only space; a write is refused.
    if (sel_capture)
    begin
      next_state.rsp.rdata = state.err_addr;
      if (csr_write)
      begin
        next_state.rsp.illegal = 1'b1;
      end
    end

    // Unlock takes any value and reads back as zero.
    if (sel_unlock)
    begin
      next_state.rsp.rdata = READ_ZERO;
      if (csr_write)
      begin
        next_state.locked = 1'b0;
      end
    end

    // An error in the same cycle as an unlock of the capture is not taken; the old lock still gates it.
    next_state.nmi_req      = 1'b0;
    next_state.nmi_pin_prev = I_NMI_PIN;
    if (err_take)
    begin
      next_state.err_addr  = I_BUS_ERR_ADDR;
      next_state.locked    = 1'b1;
      next_state.nmi_req   = 1'b1;
      next_state.nmi_cause = I_BUS_ERR_LOAD ? NMI_CAUSE_LOAD
                                            : NMI_CAUSE_STORE;
      // A pin request in this cycle waits one cycle rather than vanish.
      if (pin_edge)
      begin
        next_state.pin_pending = 1'b1;
      end
    end
    else if (pin_edge || state.pin_pending)
    begin
      // Pin requests pass whether or not the capture is locked.
      next_state.nmi_req     = 1'b1;
      next_state.nmi_cause   = NMI_CAUSE_PIN;
      next_state.pin_pending = 1'b0;
    end

    // Attributes are registered, which costs one cycle of lookup latency.
    next_state.fetch_attr = fetch_attr_comb;
    next_state.data_attr  = data_attr_comb;

    // Partial writes: local ones ask for a merge with fresh check bits.
    next_state.local_rmw      = I_STORE.valid && I_STORE.local_mem
                                && partial;
    next_state.local_rmw_addr = I_STORE.addr;

    // System writes go out with their byte lanes; the target merges.
    next_state.sys_wr_valid = I_STORE.valid && !I_STORE.local_mem;
    next_state.sys_wr_addr  = I_STORE.addr;
    next_state.sys_wr_strb  = I_STORE.strb;
  end

  // Synchronous reset puts every field to its documented value.
  always_ff @(posedge I_CLOCK)
  begin
    if (!I_RST_N)
    begin
      state             <= '0;
      state.region_attr <= REGION_ATTR_RESET;
      state.err_addr    <= ERR_CAPTURE_RESET;
      state.locked      <= 1'b0;
      state.nmi_cause   <= NMI_CAUSE_PIN;
    end
    else
    begin
      state <= next_state;
    end
  end

  // Every output is a field of the registered state.
  assign O_CSR_RSP         = state.rsp;
  assign O_FETCH_ATTR      = state.fetch_attr;
  assign O_DATA_ATTR       = state.data_attr;
  assign O_DATA_FENCE_REQ  = state.data_fence;
  assign O_INSTR_FENCE_REQ = state.instr_fence;
  assign O_NMI_REQ         = state.nmi_req;
  assign O_NMI_CAUSE       = state.nmi_cause;
  assign O_ERR_CAPTURE     = state.err_addr;
  assign O_ERR_LOCKED      = state.locked;
  assign O_LOCAL_RMW_REQ   = state.local_rmw;
  assign O_LOCAL_RMW_ADDR  = state.local_rmw_addr;
  assign O_SYS_WR_VALID    = state.sys_wr_valid;
  assign O_SYS_WR_ADDR     = state.sys_wr_addr;
  assign O_SYS_WR_STRB     = state.sys_wr_strb;

endmodule // platform_csr_bank

// [hw/platform_csr_pkg.sv]
// Package with offsets, field layout, reset values and carriers of the bank.
package platform_csr_pkg;

  // Register numbers in the core's control/status address space.
  localparam logic [11:0] REGION_ATTR_ADDR  = 12'h7C0;
  localparam logic [11:0] SYNC_TRIGGER_ADDR = 12'h7C4;
  localparam logic [11:0] ERR_UNLOCK_ADDR   = 12'hBC0;
  localparam logic [11:0] ERR_CAPTURE_ADDR  = 12'hFC0;

  // Region attribute layout: one pair of bits per region.
  localparam int REGION_COUNT     = 16;
  localparam int REGION_SEL_MSB   = 31;
  localparam int REGION_SEL_LSB   = 28;
  localparam int ATTR_PAIR_WIDTH  = 2;
  localparam int SIDE_EFFECT_BIT  = 1;
  localparam int CACHEABLE_BIT    = 0;

  // Trigger bit positions.
  localparam int DATA_FENCE_BIT   = 1;
  localparam int INSTR_FENCE_BIT  = 0;

  // Reset values.
  localparam logic [31:0] REGION_ATTR_RESET = 32'h0000_0000;
  localparam logic [31:0] ERR_CAPTURE_RESET = 32'h0000_0000;
  localparam logic [31:0] READ_ZERO         = 32'h0000_0000;

  // Cause codes reported with a non-maskable interrupt.
  localparam logic [31:0] NMI_CAUSE_PIN   = 32'h0000_0000;
  localparam logic [31:0] NMI_CAUSE_STORE = 32'hF000_0000;
  localparam logic [31:0] NMI_CAUSE_LOAD  = 32'hF000_0001;

  // Byte strobes that mark a whole word.
  localparam logic [3:0]  FULL_STRB       = 4'hF;

  typedef enum logic
  {
    ACCESS_FETCH = 1'b0,
    ACCESS_DATA  = 1'b1
  } access_kind_t;

  typedef struct packed
  {
    logic side_effect;
    logic cacheable;
  } mem_attr_t;

  typedef struct packed
  {
    logic        valid;
    logic        we;
    logic [11:0] addr;
    logic [31:0] wdata;
    logic        debug_mode;
  } csr_req_t;

  typedef struct packed
  {
    logic        ack;
    logic        hit;
    logic        illegal;
    logic [31:0] rdata;
  } csr_rsp_t;

  typedef struct packed
  {
    logic        valid;
    logic        local_mem;
    logic [31:0] addr;
    logic [3:0]  strb;
  } store_t;

  // Region index of an address, from its four top bits.
  function automatic logic [3:0] region_of(input logic [31:0] addr);
    return addr[REGION_SEL_MSB:REGION_SEL_LSB];
  endfunction

endpackage

// [hw/region_attr_resolve.sv]
// Resolves the effective attributes of one access from the attribute word.
module region_attr_resolve
  import platform_csr_pkg::*;
(
  input  wire logic [31:0]  i_attr_word,
  input  wire logic [31:0]  i_addr,
  input  wire access_kind_t i_kind,
  input  wire logic         i_local_target,
  output mem_attr_t         o_attr
);

  logic [3:0] region;
  logic [1:0] pair;

  // Pick the pair of the addressed region.
  assign region = region_of(i_addr);
  assign pair   = i_attr_word[region * ATTR_PAIR_WIDTH +: ATTR_PAIR_WIDTH];

  // The stored pair stays as written; only its use is remapped here.
  always_comb
  begin
    o_attr.side_effect = pair[SIDE_EFFECT_BIT];
    o_attr.cacheable   = pair[CACHEABLE_BIT];
    if (pair[SIDE_EFFECT_BIT] && pair[CACHEABLE_BIT])
    begin
      // The illegal pair means cacheable for fetches, side effect for data.
      o_attr.side_effect = (i_kind == ACCESS_DATA);
      o_attr.cacheable   = (i_kind == ACCESS_FETCH);
    end
    if (i_kind == ACCESS_FETCH)
    begin
      // Fetches never see side effects.
      o_attr.side_effect = 1'b0;
      // Fetches from local instruction memory are never cached.
      if (i_local_target)
      begin
        o_attr.cacheable = 1'b0;
      end
    end
    else if (i_local_target)
    begin
      // Local memories and interrupt controller registers are idempotent.
      o_attr.side_effect = 1'b0;
    end
  end

endmodule // region_attr_resolve

// [sim/platform_csr_properties.sv]
// Checker of the register bank's port behaviour, bound to the bank.
module platform_csr_checker
  import platform_csr_pkg::*;
(
  input wire logic        I_CLOCK,
  input wire logic        I_RST_N,
  input wire csr_req_t    I_CSR_REQ,
  input wire csr_rsp_t    O_CSR_RSP,
  input wire logic        O_DATA_FENCE_REQ,
  input wire logic        I_BUS_ERR,
  input wire logic        I_BUS_ERR_LOAD,
  input wire logic [31:0] I_BUS_ERR_ADDR,
  input wire logic        I_NMI_PIN,
  input wire logic        O_NMI_REQ,
  input wire logic [31:0] O_NMI_CAUSE,
  input wire logic [31:0] O_ERR_CAPTURE,
  input wire logic        O_ERR_LOCKED,
  input wire store_t      I_STORE,
  input wire logic        O_LOCAL_RMW_REQ,
  input wire logic        O_SYS_WR_VALID,
  input wire logic [3:0]  O_SYS_WR_STRB
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (!I_RST_N);
  // Decoded requests; a taken error is one that arrives while unlocked.
  wire logic trig = I_CSR_REQ.valid && I_CSR_REQ.addr == SYNC_TRIGGER_ADDR;
  wire logic unl  = I_CSR_REQ.valid && I_CSR_REQ.addr == ERR_UNLOCK_ADDR;
  wire logic take = I_BUS_ERR && !O_ERR_LOCKED;
  trig_debug_only_a: assert property (
    trig && !I_CSR_REQ.debug_mode
    |=> O_CSR_RSP.illegal && !O_DATA_FENCE_REQ)
    else $error("trigger open");
  trig_read_zero_a: assert property (
    trig |=> O_CSR_RSP.rdata == READ_ZERO)
    else $error("trigger read not zero");
  data_fence_a: assert property (
    trig && I_CSR_REQ.we && I_CSR_REQ.debug_mode
    && I_CSR_REQ.wdata[DATA_FENCE_BIT] |=> O_DATA_FENCE_REQ)
    else $error("no data fence");
  unlock_zero_a: assert property (
    unl |=> O_CSR_RSP.rdata == READ_ZERO)
    else $error("unlock read not zero");
  err_capture_a: assert property (
    take |=> O_NMI_REQ && O_ERR_LOCKED
    && O_ERR_CAPTURE == $past(I_BUS_ERR_ADDR))
    else $error("capture wrong");
  err_cause_a: assert property (
    take |=> O_NMI_CAUSE
    == ($past(I_BUS_ERR_LOAD) ? NMI_CAUSE_LOAD : NMI_CAUSE_STORE))
    else $error("cause wrong");
  err_gated_a: assert property (
    O_ERR_LOCKED && I_BUS_ERR |=> $stable(O_ERR_CAPTURE))
    else $error("locked capture moved");
  unlock_frees_a: assert property (
    O_ERR_LOCKED && unl && I_CSR_REQ.we && !I_BUS_ERR |=> !O_ERR_LOCKED)
    else $error("unlock ignored");
  lock_holds_a: assert property (
    O_ERR_LOCKED && !(unl && I_CSR_REQ.we) |=> O_ERR_LOCKED)
    else $error("lock dropped");
  sys_strobe_a: assert property (
    I_STORE.valid && !I_STORE.local_mem
    |=> O_SYS_WR_VALID && O_SYS_WR_STRB == $past(I_STORE.strb))
    else $error("system write wrong");
  local_rmw_a: assert property (
    I_STORE.valid && I_STORE.local_mem && I_STORE.strb != FULL_STRB
    |=> O_LOCAL_RMW_REQ)
    else $error("no rmw");
  // A pin edge is served at once, or one cycle late behind a bus error.
  pin_nmi_pass_a: assert property (
    $rose(I_NMI_PIN)
    |-> ##[1:2] (O_NMI_REQ && O_NMI_CAUSE == NMI_CAUSE_PIN))
    else $error("pin request lost");
endmodule // platform_csr_checker

bind platform_csr_bank platform_csr_checker u_checker (.I_CLOCK, .I_RST_N,
  .I_CSR_REQ, .O_CSR_RSP, .O_DATA_FENCE_REQ, .I_BUS_ERR, .I_BUS_ERR_LOAD,
  .I_BUS_ERR_ADDR, .I_NMI_PIN, .O_NMI_REQ, .O_NMI_CAUSE, .O_ERR_CAPTURE,
  .O_ERR_LOCKED, .I_STORE, .O_LOCAL_RMW_REQ, .O_SYS_WR_VALID,
  .O_SYS_WR_STRB);

// [sim/sys_bus_model.sv]
// Model of the system data bus, faulting on accesses to one region.
module sys_bus_model
#(
  parameter logic [3:0] FAULT_REGION = 4'hE
)
(
  input  wire logic        i_clock,
  input  wire logic        i_rst_n,
  input  wire logic        i_wr_valid,
  input  wire logic [31:0] i_wr_addr,
  input  wire logic        i_load_valid,
  input  wire logic [31:0] i_load_addr,
  output logic             o_err,
  output logic             o_err_load,
  output logic [31:0]      o_err_addr
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {o_err, o_err_load, o_err_addr} = '0;
  // Errors come one cycle after the access; idle address lines toggle so
  // that a stale address cannot pass for a fresh one.
  always @(posedge i_clock)
  begin
    o_err <= 1'b0;
    o_err_load <= ~o_err_load;
    o_err_addr <= ~o_err_addr;
    if (!i_rst_n)
      o_err_addr <= '0;
    else if (i_wr_valid && i_wr_addr[31:28] == FAULT_REGION)
      {o_err, o_err_load, o_err_addr} <= {2'b10, i_wr_addr};
    else if (i_load_valid && i_load_addr[31:28] == FAULT_REGION)
      {o_err, o_err_load, o_err_addr} <= {2'b11, i_load_addr};
  end
endmodule // sys_bus_model

// [sim/test_platform_csr_region_and_bus_error.sv]
// Self-checking bench of the platform register bank.
module test_platform_csr_region_and_bus_error
  import platform_csr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock, rst_n, f_loc, d_loc, d_fence, i_fence, bus_err, bus_load;
  logic pin, nmi, locked, rmw, sys_v, load_v;
  logic [31:0] f_addr, d_addr, bus_addr, cause, capt, rmw_a, sys_a, load_a;
  logic [31:0] seed, w, a;
  logic [3:0] sys_s;
  logic [11:0] regs [5];
  csr_req_t req;
  csr_rsp_t rsp;
  mem_attr_t f_attr, d_attr;
  store_t st;
  int err_total, cmp_count, cycles, nmis, k0;

  platform_csr_bank DUT (.I_CLOCK(clock), .I_RST_N(rst_n), .I_CSR_REQ(req),
    .O_CSR_RSP(rsp), .I_FETCH_ADDR(f_addr), .I_FETCH_LOCAL(f_loc),
    .O_FETCH_ATTR(f_attr), .I_DATA_ADDR(d_addr), .I_DATA_LOCAL(d_loc),
    .O_DATA_ATTR(d_attr), .O_DATA_FENCE_REQ(d_fence),
    .O_INSTR_FENCE_REQ(i_fence), .I_BUS_ERR(bus_err),
    .I_BUS_ERR_LOAD(bus_load), .I_BUS_ERR_ADDR(bus_addr), .I_NMI_PIN(pin),
    .O_NMI_REQ(nmi), .O_NMI_CAUSE(cause), .O_ERR_CAPTURE(capt),
    .O_ERR_LOCKED(locked), .I_STORE(st), .O_LOCAL_RMW_REQ(rmw),
    .O_LOCAL_RMW_ADDR(rmw_a), .O_SYS_WR_VALID(sys_v), .O_SYS_WR_ADDR(sys_a),
    .O_SYS_WR_STRB(sys_s));
  sys_bus_model u_bus (.i_clock(clock), .i_rst_n(rst_n), .i_wr_valid(sys_v),
    .i_wr_addr(sys_a), .i_load_valid(load_v), .i_load_addr(load_a),
    .o_err(bus_err), .o_err_load(bus_load), .o_err_addr(bus_addr));

  // Next value of the random source.
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Effective attributes that an access should see.
  function automatic mem_attr_t want(input logic [31:0] wd, ad,
                                     input logic dat, loc);
    logic [1:0] p;
    p = wd[ad[31:28] * 2 +: 2];
    if (p == 2'b11) p = dat ? 2'b10 : 2'b01;
    if (!dat || loc) p[1] = 1'b0;
    if (!dat && loc) p[0] = 1'b0;
    return p;
  endfunction
  // Wide enough for a flag, a field and a word compared together.
  task automatic chk(input logic [63:0] got, exp);
    cmp_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic tick;
    @(posedge clock);
    #1;
  endtask
  // One register access; the answer stands in the cycle after it.
  task automatic csr(input logic we, input logic [11:0] ad,
                     input logic [31:0] d, input logic dbg);
    tick;
    req = '{1'b1, we, ad, d, dbg};
    tick;
    req.valid = 1'b0;
  endtask
  task automatic put(input logic loc, input logic [31:0] ad,
                     input logic [3:0] s);
    st = '{1'b1, loc, ad, s};
    tick;
    st.valid = 1'b0;
  endtask
  task automatic give_verdict;
    $display("Counts: %0d compares, %0d mismatches", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // The run is well under a thousand cycles, so this cuts only a hang.
  always @(posedge clock)
  begin
    cycles++;
    nmis += (nmi === 1'b1);
    if (cycles == 3000)
    begin
      err_total++;
      give_verdict;
    end
  end

  initial
  begin
    {req, f_addr, d_addr, f_loc, d_loc, pin, st, load_v, load_a} = '0;
    rst_n = 1'b0;
    seed = 32'h1ee1;
    regs = '{REGION_ATTR_ADDR, ERR_CAPTURE_ADDR, ERR_UNLOCK_ADDR,
             SYNC_TRIGGER_ADDR, 12'h123};
    repeat (16) @(posedge clock);
    #1 rst_n = 1'b1;
    foreach (regs[k])
    begin
      csr(1'b0, regs[k], '0, 1'b1);
      chk(rsp.rdata, READ_ZERO);
      chk({rsp.ack, rsp.hit}, {1'b1, k != 4});
    end
    csr(1'b1, ERR_UNLOCK_ADDR, seed, 1'b0);
    chk(rsp.rdata, READ_ZERO);
    $display("test reset_values done");
    for (int n = 0; n < 24; n++)
    begin
      seed = lfsr(seed);
      w = n == 0 ? '1 : n == 1 ? 32'h5555_5555 : seed;
      csr(1'b1, REGION_ATTR_ADDR, w, 1'b0);
      csr(1'b0, REGION_ATTR_ADDR, '0, 1'b0);
      chk(rsp.rdata, w);
      for (int r = 0; r < 16; r++)
      begin
        seed = lfsr(seed);
        f_addr = {r[3:0], seed[27:0]};
        d_addr = {r[3:0] ^ 4'h5, seed[31:4]};
        {f_loc, d_loc} = seed[1:0];
        tick;
        chk(f_attr, want(w, f_addr, 1'b0, f_loc));
        chk(d_attr, want(w, d_addr, 1'b1, d_loc));
      end
    end
    csr(1'b1, SYNC_TRIGGER_ADDR, 32'h0000_0003, 1'b1);
    chk({d_fence, i_fence, rsp.rdata}, 34'h3_0000_0000);
    csr(1'b1, SYNC_TRIGGER_ADDR, 32'h0000_0002, 1'b1);
    chk({d_fence, i_fence}, 2'b10);
    csr(1'b1, SYNC_TRIGGER_ADDR, 32'h0000_0003, 1'b0);
    chk({rsp.illegal, d_fence, i_fence}, 3'b100);
    $display("test regions_and_triggers done");
    put(1'b1, 32'h0004_0012, 4'h3);
    chk({rmw, rmw_a}, {1'b1, 32'h0004_0012});
    a = {4'hE, seed[27:2], 2'b00};
    put(1'b0, a, 4'h6);
    chk({sys_v, sys_s, sys_a}, {1'b1, 4'h6, a});
    k0 = nmis;
    repeat (2) tick;
    chk({locked, cause}, {1'b1, NMI_CAUSE_STORE});
    csr(1'b1, ERR_CAPTURE_ADDR, '0, 1'b0);
    chk({rsp.illegal, rsp.rdata}, {1'b1, a});
    load_v = 1'b1;
    load_a = {4'hE, seed[31:4]};
    tick;
    load_v = 1'b0;
    repeat (2) tick;
    chk({capt, nmis}, {a, k0 + 1});
    pin = 1'b1;
    repeat (2) tick;
    chk({cause, nmis}, {NMI_CAUSE_PIN, k0 + 2});
    // Drop the pin so that the next rise is a fresh request.
    pin = 1'b0;
    csr(1'b1, ERR_UNLOCK_ADDR, '0, 1'b0);
    chk(locked, 1'b0);
    load_v = 1'b1;
    tick;
    load_v = 1'b0;
    // The pin rises in the very cycle that the bus error is taken.
    pin = 1'b1;
    tick;
    chk({cause, capt}, {NMI_CAUSE_LOAD, load_a});
    tick;
    chk({cause, nmis}, {NMI_CAUSE_PIN, k0 + 3});
    pin = 1'b0;
    rst_n = 1'b0;
    tick;
    rst_n = 1'b1;
    chk({locked, capt}, '0);
    chk(nmis, k0 + 4);
    $display("test bus_errors done");
    give_verdict;
  end
endmodule // test_platform_csr_region_and_bus_error
